// file: rtl/usu_pkg.sv
// constants shared by the universal serial unit design files
// assumes a 100 MHz system clock and a synchronous active-high reset
package usu_pkg;

   // wire mode encoding, driven by the two wire-mode control bits
   typedef enum logic [1:0] {
      USU_WM_OFF   = 2'b00,   // outputs idle, inputs still usable
      USU_WM_THREE = 2'b01,   // spi mode 0/1 peripheral, no select
      USU_WM_TWO   = 2'b10,   // open-drain two-wire
      USU_WM_TWOH  = 2'b11    // two-wire, same behaviour here
   } usu_wm_e;

   // system clock period
   localparam int USU_CLK_PERIOD_NS = 10;

   // sda delay window for start detection
   localparam int USU_SDA_DLY_MIN_NS = 50;
   localparam int USU_SDA_DLY_MAX_NS = 300;
   // least time rounds up to whole cycles
   localparam int USU_SDA_DLY_CYC =
      (USU_SDA_DLY_MIN_NS + USU_CLK_PERIOD_NS - 1) / USU_CLK_PERIOD_NS;
   // longest allowed delay, rounded down
   localparam int USU_SDA_DLY_MAX_CYC = USU_SDA_DLY_MAX_NS / USU_CLK_PERIOD_NS;

   // serial clock must be at most a quarter of the system clock
   localparam int USU_SCK_DIV_MIN = 4;

   // register widths and reset values
   localparam int         USU_DATA_W     = 8;
   localparam int         USU_CNT_W      = 4;
   localparam logic [7:0] USU_DATA_RST   = 8'h00;
   localparam logic [3:0] USU_CNT_RST    = 4'h0;
   localparam logic [3:0] USU_CNT_MAX    = 4'hF;
   localparam int         USU_MSB        = 7;
   localparam int         USU_SYNC_W     = 3;
   localparam int         USU_SYNC_DIN   = 0;
   localparam int         USU_SYNC_SCL   = 1;
   localparam int         USU_SYNC_REQ   = 2;

endpackage

// file: rtl/usu_sync.sv
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a level that stays stable for several clocks
`timescale 1ns/1ps

module usu_sync #(
   parameter int WIDTH = 3          // number of levels crossed
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;      // first stage, read only by stage two

   // first stage only feeds second stage to keep metastability contained
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // usu_sync

// file: rtl/usu_start_det.sv
// asynchronous two-wire start condition detector
// clocked by the sda wire itself, so it works with the system clock stopped
// assumes ack_clr comes from a system-clock register and is held until seen
`timescale 1ns/1ps

module usu_start_det (
   input  wire logic sda_link_clk,  // sda line used as this domain's clock
   input  wire logic scl_level,     // scl line as seen at the sda edge
   input  wire logic enable,        // two-wire mode, quasi-static
   input  wire logic ack_clr,       // handshake acknowledge, clears request
   output logic      start_req      // level request toward system domain
);

   // a falling sda while scl is high is a start; the request stays up
   // until the system side acknowledges, so no edge is lost unless ack_clr is still high
   always_ff @(negedge sda_link_clk or posedge ack_clr) begin
      if (ack_clr) begin
         start_req <= 1'b0;
      end else if (enable && scl_level) begin
         start_req <= 1'b1;
      end
   end

endmodule // usu_start_det

// file: rtl/usu_top.sv
// universal serial unit: shift register, edge counter, wire control
// Operation
// - three-wire is spi mode 0/1, no select
// - eight clocks swap bytes and advance counter
// - edge select 0: sample rise, shift fall
// - edge select 1: sample fall, shift rise
// - master clock by port bit or toggle strobe
// - external clock counts both edges, sixteen overflow
// - overflow flag can wake idle processor
// - serial clock at most quarter system clock
// - msb drives output only when direction set
// - two-wire without slew limit or filtering
// - start is sda falling with scl high
// - hold scl low after start until cleared
// - sda low from msb zero or port zero
// - two-wire slave samples sda on rising scl
// - eight bits overflow counter, scl forced low
// - direction bit decides who drives data
// - start detect two-wire only, sda delayed
// - start detector works without system clock
// - overflow at wrap, write-one clears, releases scl
// - clearing start flag releases start scl hold
// assumes pins and sda_link_clk come from outside; control ports from logic
// on clk_sys; strobes are one-cycle pulses
`timescale 1ns/1ps

module usu_top #(
   parameter int SDA_DLY = usu_pkg::USU_SDA_DLY_CYC  // sda delay in cycles
) (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       sda_link_clk,
   input  wire logic       serial_in_pin,
   input  wire logic       serial_clock_pin_i,
   output logic            serial_clock_pin_o,
   output logic            serial_clock_pin_oe,
   output logic            data_out_o,
   output logic            data_out_oe,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic [1:0] wire_mode,
   input  wire logic       external_clock_select,
   input  wire logic       clock_edge_select,
   input  wire logic       clock_strobe_bit,
   input  wire logic       clock_toggle_strobe,
   input  wire logic       timer_match,
   input  wire logic       port_data_out,
   input  wire logic       port_data_dir,
   input  wire logic       port_clock_wr,
   input  wire logic       port_clock_wdata,
   input  wire logic       port_clock_dir,
   input  wire logic       shift_data_wr,
   input  wire logic [7:0] shift_data_wdata,
   output logic      [7:0] shift_data_reg,
   input  wire logic       counter_wr,
   input  wire logic [3:0] counter_wdata,
   output logic      [3:0] counter_value,
   input  wire logic       overflow_clear,
   input  wire logic       start_clear,
   output logic            counter_overflow_flag,
   output logic            start_condition_flag,
   output logic            wake_idle,
   output logic            wake_start
);


   // declarations

   logic [usu_pkg::USU_SYNC_W-1:0] sync_in;   // raw levels to cross
   logic [usu_pkg::USU_SYNC_W-1:0] sync_lvl;  // crossed levels
   logic       din_s;            // synchronised serial input
   logic       scl_s;            // synchronised serial clock
   logic       req_s;            // synchronised start request
   logic       start_req;        // request from async detector
   logic       scl_prev_reg;     // last scl level, for edges
   logic       req_prev_reg;     // last request level
   logic       ack_reg;          // handshake acknowledge
   logic       ack_next;
   logic       scl_rise;         // rising edge of synced scl
   logic       scl_fall;         // falling edge of synced scl
   logic       two_wire;         // either two-wire encoding
   logic       three_wire;       // three-wire encoding
   logic       sample_edge;      // external edge that samples input
   logic       sw_clk;           // internal clock source pulse
   logic       shift_evt;        // shift register advance
   logic       cnt_evt;          // counter advance
   logic       cnt_wrap;         // counter passes 15 to 0
   logic       latch_open;       // output latch transparent
   logic       async_start;      // start seen by async detector
   logic       sync_start;       // start seen by delayed sampler
   logic       start_evt;        // any start condition
   logic       scl_hold;         // slave pulls scl low
   logic [SDA_DLY-1:0] sda_dly_reg;   // sda delay line
   logic [SDA_DLY-1:0] sda_dly_next;
   logic       sda_dly_prev_reg; // delayed sda, one cycle older
   logic [7:0] shift_next;
   logic [3:0] cnt_next;
   logic       ovf_next;
   logic       start_next;
   logic       start_hold_reg;   // scl held after start
   logic       start_hold_next;
   logic       out_latch_reg;    // output latch holding shifted msb
   logic       out_latch_next;
   logic       clk_port_reg;     // serial clock port bit
   logic       clk_port_next;


   // pin synchronisers and async start detector

   assign sync_in[usu_pkg::USU_SYNC_DIN] = serial_in_pin;
   assign sync_in[usu_pkg::USU_SYNC_SCL] = serial_clock_pin_i;
   assign sync_in[usu_pkg::USU_SYNC_REQ] = start_req;

   // all three inputs are foreign to clk_sys, crossed together
   usu_sync #(
      .WIDTH    (usu_pkg::USU_SYNC_W)
   ) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in (sync_in),
      .sync_out (sync_lvl)
   );

   assign din_s = sync_lvl[usu_pkg::USU_SYNC_DIN];
   assign scl_s = sync_lvl[usu_pkg::USU_SYNC_SCL];
   assign req_s = sync_lvl[usu_pkg::USU_SYNC_REQ];

   // detector only armed in two-wire mode
   usu_start_det u_start (
      .sda_link_clk (sda_link_clk),
      .scl_level    (serial_clock_pin_i),
      .enable       (two_wire),
      .ack_clr      (ack_reg),
      .start_req    (start_req)
   );

   // wake output needs no system clock at all
   assign wake_start = start_req;


   // mode decode

   assign two_wire   = wire_mode[1];
   assign three_wire = (wire_mode == usu_pkg::USU_WM_THREE);


   // edge and clock source selection

   // edges are taken from the synced level, so each scl level must last
   // at least two system clocks: a limit of a quarter system clock
   assign scl_rise = scl_s & ~scl_prev_reg;
   assign scl_fall = ~scl_s & scl_prev_reg;

   // edge select low samples on rise (also two-wire rise sampling)
   assign sample_edge = external_clock_select &
                        (clock_edge_select ? scl_fall : scl_rise);

   // internal sources: software strobe or timer match
   assign sw_clk = ~external_clock_select &
                   (clock_edge_select ? timer_match : clock_strobe_bit);

   assign shift_evt = sample_edge | sw_clk;

   // external clock counts every edge unless strobe counting chosen
   assign cnt_evt = external_clock_select ?
                    (clock_strobe_bit ? clock_toggle_strobe
                                      : (scl_rise | scl_fall))
                    : sw_clk;

   assign cnt_wrap = cnt_evt & ~counter_wr &
                     (counter_value == usu_pkg::USU_CNT_MAX);


   // shift register

   // a software write in the same cycle as a shift wins outright
   always_comb begin
      shift_next = shift_data_reg;
      if (shift_data_wr) begin
         shift_next = shift_data_wdata;
      end else if (shift_evt) begin
         shift_next = {shift_data_reg[6:0], din_s};
      end
   end


   // edge counter and overflow flag

   always_comb begin
      cnt_next = counter_value;
      if (counter_wr) begin
         cnt_next = counter_wdata;   // preset, e.g. for one-bit ack
      end else if (cnt_evt) begin
         cnt_next = counter_value + 4'h1;
      end
   end

   // setting beats a write-one clear in the same cycle
   assign ovf_next = cnt_wrap |
                     (counter_overflow_flag & ~overflow_clear);

   // overflow doubles as the idle wake request
   assign wake_idle = counter_overflow_flag;


   // output latch

   // open always with internal clock; with external clock open during
   // the half before the sampling edge, so output moves on the edge opposite to sampling
   assign latch_open = ~external_clock_select |
                       (scl_s == clock_edge_select);
   assign out_latch_next = latch_open ? shift_next[usu_pkg::USU_MSB]
                                      : out_latch_reg;


   // clock port bit: master makes the serial clock in software

   always_comb begin
      clk_port_next = clk_port_reg;
      if (port_clock_wr) begin
         clk_port_next = port_clock_wdata;
      end else if (clock_toggle_strobe) begin
         clk_port_next = ~clk_port_reg;
      end
   end


   // start condition: delayed sda sampled against scl

   // sda is delayed behind scl so a start is judged on a settled scl
   generate
      if (SDA_DLY > 1) begin : g_dly
         assign sda_dly_next = {sda_dly_reg[SDA_DLY-2:0], din_s};
      end else begin : g_dly1
         assign sda_dly_next = din_s;
      end
   endgenerate

   assign sync_start = two_wire & scl_s &
                       sda_dly_prev_reg & ~sda_dly_reg[SDA_DLY-1];

   // handshake: new request seen while not yet acknowledged
   assign async_start = req_s & ~req_prev_reg & ~ack_reg;
   assign ack_next    = req_s;   // four-phase, ack follows request

   assign start_evt = sync_start | async_start;

   // set wins over a write-one clear
   assign start_next = start_evt |
                       (start_condition_flag & ~start_clear);

   // after a start, catch the master's falling scl and keep holding
   assign start_hold_next = start_next & two_wire &
                            (start_hold_reg | scl_fall);


   // scl hold: start hold or overflow hold, two-wire only

   assign scl_hold = two_wire &
                     (start_hold_reg | counter_overflow_flag);


   // pin drivers

   // three-wire: push-pull data out, no select pin exists here
   assign data_out_o  = out_latch_reg;
   assign data_out_oe = three_wire & port_data_dir;

   // two-wire: open drain, only ever pulls low; no slew control or
   // input filter, which the user must tolerate on long lines
   assign sda_o  = 1'b0;
   assign sda_oe = two_wire & port_data_dir &
                   (~out_latch_reg | ~port_data_out);

   // serial clock: push-pull in three-wire, open drain in two-wire
   always_comb begin
      serial_clock_pin_o  = 1'b0;
      serial_clock_pin_oe = 1'b0;
      if (three_wire) begin
         serial_clock_pin_o  = clk_port_reg;
         serial_clock_pin_oe = port_clock_dir;
      end else if (two_wire) begin
         serial_clock_pin_oe = (port_clock_dir & ~clk_port_reg) |
                               scl_hold;
      end
   end


   // state registers

   // data path registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_data_reg <= usu_pkg::USU_DATA_RST;
         counter_value  <= usu_pkg::USU_CNT_RST;
         out_latch_reg  <= 1'b0;
      end else begin
         shift_data_reg <= shift_next;
         counter_value  <= cnt_next;
         out_latch_reg  <= out_latch_next;
      end
   end

   // flags and holds
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         counter_overflow_flag <= 1'b0;
         start_condition_flag  <= 1'b0;
         start_hold_reg        <= 1'b0;
         clk_port_reg          <= 1'b0;
      end else begin
         counter_overflow_flag <= ovf_next;
         start_condition_flag  <= start_next;
         start_hold_reg        <= start_hold_next;
         clk_port_reg          <= clk_port_next;
      end
   end

   // edge history and handshake; ack held high in reset so the
   // async request is forced clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         scl_prev_reg     <= 1'b0;
         req_prev_reg     <= 1'b0;
         ack_reg          <= 1'b1;
         sda_dly_reg      <= '1;
         sda_dly_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg     <= scl_s;
         req_prev_reg     <= req_s;
         ack_reg          <= ack_next;
         sda_dly_reg      <= sda_dly_next;
         sda_dly_prev_reg <= sda_dly_reg[SDA_DLY-1];
      end
   end

endmodule // usu_top

// file: verif/usu_checker_assertions.sv
// checker: flag, counter and pin-enable relations of the serial unit
// assumes it is bound onto usu_top and that all of it runs on clk_sys
`timescale 1ns/1ps

module usu_checker (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic [1:0] wire_mode,
   input wire logic       port_data_dir,
   input wire logic       data_out_oe,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic       shift_data_wr,
   input wire logic [7:0] shift_data_wdata,
   input wire logic [7:0] shift_data_reg,
   input wire logic       counter_wr,
   input wire logic [3:0] counter_value,
   input wire logic       overflow_clear,
   input wire logic       counter_overflow_flag,
   input wire logic       clock_strobe_bit,
   input wire logic       external_clock_select,
   input wire logic       clock_edge_select,
   input wire logic       serial_clock_pin_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // a software write must beat a shift in the same cycle
   wr_wins_a: assert property (
      shift_data_wr |=> shift_data_reg == $past(shift_data_wdata)) else $error("shift write lost");
   // software strobe advances the counter by exactly one
   strobe_count_a: assert property (
      clock_strobe_bit && !external_clock_select && !clock_edge_select && !counter_wr
      |=> counter_value == $past(counter_value) + 4'h1) else $error("strobe count wrong");
   // wrap from fifteen to zero raises the overflow flag
   wrap_flag_a: assert property (
      $past(counter_value) == 4'hF && counter_value == 4'h0 && !$past(counter_wr)
      |-> counter_overflow_flag) else $error("wrap without overflow flag");
   // flag is sticky until a clear
   ovf_sticky_a: assert property (
      counter_overflow_flag && !overflow_clear |=> counter_overflow_flag) else $error("flag lost");
   // a clear with no wrap pending empties the flag
   ovf_clear_a: assert property (
      overflow_clear && counter_value != 4'hF |=> !counter_overflow_flag) else $error("no clear");
   // data output driven only in three-wire with direction set
   do_enable_a: assert property (
      data_out_oe == (wire_mode == 2'b01 && port_data_dir)) else $error("data enable wrong");
   // sda only ever pulled low, two-wire with direction set
   sda_pull_a: assert property (
      sda_oe |-> wire_mode[1] && port_data_dir && !sda_o) else $error("sda drive wrong");
   // overflow in two-wire keeps the clock pin held
   scl_hold_a: assert property (
      (counter_overflow_flag && wire_mode[1]) [*2] |-> serial_clock_pin_oe) else $error("no hold");

   cover property (counter_overflow_flag && wire_mode[1]);
   cover property (shift_data_wr && clock_strobe_bit);
   cover property (sda_oe);
endmodule // usu_checker

// file: verif/usu_far_master.sv
// far-side serial master model: spi modes 0/1 and two-wire start and bytes
// assumes the bench resolves the shared wires and feeds them back here
`timescale 1ns/1ps

module usu_far_master #(
   parameter int HALF = 64   // half serial period in ns, far below the quarter-rate ceiling
) (
   input  wire logic scl_wire,   // resolved clock wire
   input  wire logic miso,       // design data output
   output logic      scl_m,      // clock drive, 1 releases in two-wire
   output logic      sda_m       // data drive, 1 releases in two-wire
);
   initial begin
      scl_m = 1'b0;
      sda_m = 1'b1;
   end

   // direct line setting between transfers
   task automatic set_lines(input logic c, input logic d);
      scl_m = c;
      sda_m = d;
   endtask

   // one byte exchange, msb first; mode 1 moves data on the rise
   task automatic spi_xfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
      #3;
      rx = 8'h00;
      if (!mode) sda_m = tx[7];
      #HALF;
      for (int i = 7; i >= 0; i--) begin
         scl_m = 1'b1;
         if (mode) sda_m = tx[i];
         else rx = {rx[6:0], miso};
         #HALF;
         scl_m = 1'b0;
         if (mode) rx = {rx[6:0], miso};
         else if (i > 0) sda_m = tx[i-1];
         #HALF;
      end
      // a released line must not look like held data
      sda_m = ~sda_m;
   endtask

   // start: data falls while the clock is high, then clock goes low
   task automatic i2c_start();
      #3;
      scl_m = 1'b1;
      sda_m = 1'b1;
      #HALF;
      sda_m = 1'b0;
      #HALF;
      scl_m = 1'b0;
      #HALF;
   endtask

   // eight bits, each rising edge checked against a stretching slave
   task automatic i2c_byte(input logic [7:0] tx, output logic ok);
      int n;
      ok = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         sda_m = tx[i];
         #HALF;
         scl_m = 1'b1;
         n = 0;
         while (scl_wire !== 1'b1 && n < 400) begin
            #1;
            n++;
         end
         if (n >= 400) ok = 1'b0;
         #HALF;
         scl_m = 1'b0;
         #HALF;
      end
      sda_m = 1'b1;
   endtask
endmodule // usu_far_master

// file: verif/testbench.sv
// self-checking bench for usu_top with a far-side serial master
// assumes package, design, checker and far-side model compile first
`timescale 1ns/1ps

module testbench;
   typedef struct {
      logic src; logic din; logic [7:0] wd; logic [3:0] wc;
      logic [7:0] ed; logic [3:0] ec; logic eo;
   } usu_row_s;
   // source 0 strobe 1 timer, input level, presets, expected shift/count/flag
   usu_row_s rows [4] = '{'{1'b0, 1'b1, 8'hA5, 4'h0, 8'h4B, 4'h1, 1'b0},
      '{1'b1, 1'b0, 8'h3C, 4'h7, 8'h78, 4'h8, 1'b0},
      '{1'b0, 1'b1, 8'h80, 4'hF, 8'h01, 4'h0, 1'b1},
      '{1'b1, 1'b1, 8'hFF, 4'hF, 8'hFF, 4'h0, 1'b1}};
   logic       clk_sys, srst, external_clock_select, clock_edge_select, clock_strobe_bit;
   logic       clock_toggle_strobe, timer_match, port_data_out, port_data_dir, port_clock_wr;
   logic       port_clock_wdata, port_clock_dir, shift_data_wr, counter_wr, overflow_clear;
   logic       start_clear, serial_clock_pin_o, serial_clock_pin_oe, data_out_o, data_out_oe;
   logic       sda_o, sda_oe, counter_overflow_flag, start_condition_flag, wake_idle;
   logic       wake_start, scl_m, sda_m, ok;
   logic [1:0] wire_mode;
   logic [3:0] counter_wdata, counter_value;
   logic [7:0] shift_data_wdata, shift_data_reg, rx;
   wire        scl_wire;   // clock pin as all parties see it
   wire        sda_wire;   // open-drain data wire with pull-up
   int         error_cnt = 0;
   int         cmp_count = 0;

   assign scl_wire = serial_clock_pin_oe ? serial_clock_pin_o : scl_m;
   assign sda_wire = sda_m & ~sda_oe;

   usu_top u_usu_top (.*, .sda_link_clk(sda_wire), .serial_in_pin(sda_wire),
      .serial_clock_pin_i(scl_wire));
   usu_far_master u_usu_far_master (.*, .miso(data_out_o));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   task automatic close_out();
      if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   // one-cycle strobe: 0 clock, 1 timer, 2 toggle, 3 overflow clear, 4 start clear
   task automatic pulse(input int k);
      @(negedge clk_sys);
      case (k)
         0: clock_strobe_bit = 1'b1;
         1: timer_match = 1'b1;
         2: clock_toggle_strobe = 1'b1;
         3: overflow_clear = 1'b1;
         default: start_clear = 1'b1;
      endcase
      @(negedge clk_sys);
      {clock_toggle_strobe, timer_match, overflow_clear, start_clear} = '0;
      if (k == 0) clock_strobe_bit = 1'b0;
   endtask
   // shift register and counter written together
   task automatic wr(input logic [7:0] d, input logic [3:0] c);
      @(negedge clk_sys);
      {shift_data_wr, shift_data_wdata, counter_wr, counter_wdata} = {1'b1, d, 1'b1, c};
      @(negedge clk_sys);
      {shift_data_wr, counter_wr} = 2'b00;
   endtask
   // bounded wait for the overflow flag; running out ends the run
   task automatic wait_ovf();
      int n;
      n = 0;
      while (counter_overflow_flag !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 400) begin
         error_cnt++;
         $display("Error %0t overflow never came", $time);
         close_out();
      end
   endtask

   initial begin
      {external_clock_select, clock_edge_select, clock_strobe_bit, clock_toggle_strobe,
         timer_match, port_data_out, port_data_dir, port_clock_wr, port_clock_wdata,
         port_clock_dir, shift_data_wr, counter_wr, overflow_clear, start_clear} = '0;
      {shift_data_wdata, counter_wdata, wire_mode} = 14'h0001;
      srst = 1'b1;
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_byte(shift_data_reg, 8'h00);
      chk_bit(wake_start, 1'b0);
      chk_bit(counter_overflow_flag, 1'b0);
      port_data_dir = 1'b1;
      // internal clock sources, two rows each
      for (int i = 0; i < 4; i++) begin
         clock_edge_select = rows[i].src;
         u_usu_far_master.set_lines(1'b0, rows[i].din);
         wr(rows[i].wd, rows[i].wc);
         repeat (4) @(negedge clk_sys);
         pulse(rows[i].src ? 1 : 0);
         repeat (2) @(negedge clk_sys);
         chk_byte(shift_data_reg, rows[i].ed);
         chk_byte({4'h0, counter_value}, {4'h0, rows[i].ec});
         chk_bit(wake_idle, rows[i].eo);
         chk_bit(data_out_o, rows[i].ed[7]);
         pulse(3);
         chk_bit(counter_overflow_flag, 1'b0);
      end
      // write and strobe in the same cycle
      clock_edge_select = 1'b0;
      @(negedge clk_sys);
      {shift_data_wr, shift_data_wdata, clock_strobe_bit} = {1'b1, 8'h5A, 1'b1};
      @(negedge clk_sys);
      {shift_data_wr, clock_strobe_bit} = 2'b00;
      chk_byte(shift_data_reg, 8'h5A);
      // master clocking by toggle strobe, counted with the external source
      {external_clock_select, clock_strobe_bit, port_clock_dir} = 3'b111;
      wr(8'h00, 4'h0);
      pulse(2);
      chk_bit(serial_clock_pin_o, 1'b1);
      repeat (15) pulse(2);
      wait_ovf();
      chk_bit(serial_clock_pin_o, 1'b0);
      {clock_strobe_bit, port_clock_dir} = 2'b00;
      pulse(3);
      // spi exchange in data modes 0 and 1
      for (int m = 0; m < 2; m++) begin
         clock_edge_select = m[0];
         wr(m[0] ? 8'h3A : 8'hC5, 4'h0);
         repeat (2) @(negedge clk_sys);
         u_usu_far_master.spi_xfer(m[0], m[0] ? 8'h96 : 8'h69, rx);
         wait_ovf();
         chk_byte(shift_data_reg, m[0] ? 8'h96 : 8'h69);
         chk_byte(rx, m[0] ? 8'h3A : 8'hC5);
         chk_byte({4'h0, counter_value}, 8'h00);
         pulse(3);
      end
      // two-wire slave: start, hold, release, address byte, overflow hold
      {port_data_dir, clock_edge_select} = 2'b00;
      wire_mode = 2'b10;
      u_usu_far_master.set_lines(1'b1, 1'b1);
      repeat (4) @(negedge clk_sys);
      u_usu_far_master.i2c_start();
      repeat (8) @(negedge clk_sys);
      chk_bit(start_condition_flag, 1'b1);
      chk_bit(serial_clock_pin_oe, 1'b1);
      pulse(4);
      wr(8'h00, 4'h0);
      repeat (2) @(negedge clk_sys);
      chk_bit(serial_clock_pin_oe, 1'b0);
      u_usu_far_master.i2c_byte(8'hA6, ok);
      chk_bit(ok, 1'b1);
      wait_ovf();
      chk_byte(shift_data_reg, 8'hA6);
      chk_bit(serial_clock_pin_oe, 1'b1);
      wr(8'h00, 4'hE);
      pulse(3);
      repeat (2) @(negedge clk_sys);
      chk_bit(serial_clock_pin_oe, 0);
      u_usu_far_master.set_lines(1'b1, 1'b1);
      repeat (4) @(negedge clk_sys);
      u_usu_far_master.set_lines(1'b0, 1'b1);
      wait_ovf();
      chk_bit(serial_clock_pin_oe, 1'b1);
      pulse(3);
      // sda pull-down from msb or port bit, gated by direction
      u_usu_far_master.set_lines(1'b0, 1'b1);
      for (int k = 0; k < 8; k++) begin
         {port_data_dir, port_data_out} = {k[2], k[1]};
         wr({k[0], 7'h00}, 4'h0);
         repeat (2) @(negedge clk_sys);
         chk_bit(sda_oe, k[2] & (~k[1] | ~k[0]));
      end
      close_out();
   end
endmodule // testbench

bind usu_top usu_checker u_usu_checker (.*);
